// ===== verilog/vsi_pkg.sv
/*
  Package for the counting-module interrupt logic: register offsets, field
  positions, reset values and source numbering.
  Assumes a 32-bit register port with byte offsets as printed.
*/
package vsi_pkg;
  localparam int NUM_SOURCES = 8;
  // Register offsets as byte addresses.
  localparam logic [7:0] OFS_INTERRUPT_CONFIGURATION = 8'h08;
  localparam logic [7:0] OFS_INTERRUPT_CONTROL_STATUS = 8'h0C;
  // Power-up values of both registers.
  localparam logic [31:0] RST_INTERRUPT_CONFIGURATION = 32'h00000000;
  localparam logic [7:0] RST_ENABLE = 8'h00;
  // Configuration register fields.
  localparam int CFG_MODE_BIT = 12;
  localparam int CFG_GLOBAL_EN_BIT = 11;
  localparam int CFG_LEVEL_LSB = 8;
  localparam int CFG_LEVEL_W = 3;
  localparam int CFG_VECTOR_LSB = 0;
  localparam int CFG_VECTOR_W = 8;
  localparam int CFG_USED_W = 13;
  // Control/status register fields.
  localparam int CTL_ENABLE_LSB = 0;
  localparam int CTL_DISABLE_LSB = 8;
  localparam int CTL_CLEAR_LSB = 16;
  localparam int CTL_STATUS_LSB = 24;
  localparam int CTL_INTERNAL_BIT = 14;
  localparam int CTL_BUS_REQ_BIT = 15;
  // Source numbering and sensitivity (1 = edge latched).
  localparam int SRC_LOAD_NEXT_EVENT = 0;
  localparam int SRC_THRESHOLD = 1;
  localparam int SRC_ACQ_DONE = 2;
  localparam int SRC_OVERFLOW = 3;
  localparam int SRC_ALMOST_FULL = 4;
  localparam logic [7:0] SRC_EDGE_MASK = 8'h15;
  localparam logic [7:0] SRC_USED_MASK = 8'h1F;
  // Release modes.
  typedef enum logic
  {
    VSI_RELEASE_ON_REGISTER_ACCESS = 1'b0,
    VSI_RELEASE_ON_ACKNOWLEDGE = 1'b1
  } vsi_release_t;
  // Acknowledge cycle state.
  typedef enum logic [1:0]
  {
    VSI_ACK_IDLE = 2'b00,
    VSI_ACK_DRIVE = 2'b01
  } vsi_ack_state_t;
endpackage

// ===== verilog/vsi_source_flag.sv
/*
  One interrupt source flag: edge-latched with a clear, or level-following.
  Assumes the condition input is synchronous to clk_sys.
*/
`timescale 1ns/100ps
`default_nettype none
module vsi_source_flag
#(
  parameter bit EDGE = 1'b1
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic condition,
  input wire logic clear,
  output logic flag
);
  logic cond_last;

  // Previous condition value, kept for edge detection.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      cond_last <= 1'b0;
    else
      cond_last <= condition;
  end

  // An edge in the same cycle as a clear wins so that no event is lost.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      flag <= 1'b0;
    else if (!EDGE)
      flag <= condition;
    else if (condition && !cond_last)
      flag <= 1'b1;
    else if (clear)
      flag <= 1'b0;
  end
endmodule // vsi_source_flag
`default_nettype wire

// ===== verilog/vsi_interrupt_logic.sv
/*
  Interrupt logic of a counting module: eight sources, per-source enable,
  disable and clear, two release modes, bus level and vector.
  Assumes a simple synchronous register port (one-cycle write/read strobes)
  and a bus interface that pulses ack_done when an acknowledge completes.
*/
`timescale 1ns/100ps
`default_nettype none
module vsi_interrupt_logic
#(
  parameter int THRESHOLD_W = 32
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Register port.
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  // Interrupt conditions from the counting logic.
  input wire logic mcs_mode,
  input wire logic prescale_active,
  input wire logic load_next_event_transfer,
  input wire logic prescaler_rundown,
  input wire logic clock_shadow,
  input wire logic [THRESHOLD_W-1:0] memory_word_count,
  input wire logic [THRESHOLD_W-1:0] threshold_value,
  input wire logic acquisition_complete,
  input wire logic preset_reached,
  input wire logic counter_overflow,
  input wire logic non_clearing_mode,
  input wire logic queue_almost_full,
  input wire logic queue_reset_key,
  // Bus interrupter side.
  input wire logic ack_cycle,
  input wire logic [2:0] ack_level,
  input wire logic ack_done,
  output logic irq_request,
  output logic [2:0] irq_level,
  output logic [7:0] vector_data,
  output logic vector_data_oe_n
);
  import vsi_pkg::*;

  // Elaboration checks. The word count and the threshold are compared as
  // plain unsigned numbers; wider than one register word the threshold
  // could not be loaded from the bus, so such widths are refused.
  if (THRESHOLD_W < 1 || THRESHOLD_W > 32)
  begin : g_bad_threshold_w
    $error("THRESHOLD_W out of range");
  end
  // The control word packs four source fields of eight bits each.
  if (NUM_SOURCES != 8)
  begin : g_bad_sources
    $error("NUM_SOURCES must be 8");
  end
  // The level field must sit below the global enable bit.
  if (CFG_LEVEL_LSB + CFG_LEVEL_W > CFG_GLOBAL_EN_BIT)
  begin : g_bad_level
    $error("level field overlaps the enable bit");
  end
  // The vector goes out on eight data lines.
  if (CFG_VECTOR_W != 8)
  begin : g_bad_vector
    $error("vector field must be 8 bits");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and conditions.

  logic [CFG_USED_W-1:0] configuration;
  logic [NUM_SOURCES-1:0] enable;
  logic [NUM_SOURCES-1:0] condition;
  logic [NUM_SOURCES-1:0] flag;
  logic [NUM_SOURCES-1:0] clear;
  logic [NUM_SOURCES-1:0] status;
  logic internal_flag;
  logic next_request;
  logic write_cfg;
  logic write_ctl;
  logic ack_hit;
  vsi_release_t release_mode;
  vsi_ack_state_t ack_state;

  assign write_cfg = reg_write && (reg_addr == OFS_INTERRUPT_CONFIGURATION);
  assign write_ctl = reg_write && (reg_addr == OFS_INTERRUPT_CONTROL_STATUS);
  assign release_mode = vsi_release_t'(configuration[CFG_MODE_BIT]);

  // Source conditions; the threshold source is off while the threshold is 0.
  // Switching the counting mode re-routes source 0 and source 2; if the
  // newly chosen input is already high this looks like a rising edge, so
  // software should clear those flags after a mode change.
  always_comb
  begin
    condition = '0;
    if (!mcs_mode)
      condition[SRC_LOAD_NEXT_EVENT] = clock_shadow;
    else if (prescale_active)
      condition[SRC_LOAD_NEXT_EVENT] = prescaler_rundown;
    else
      condition[SRC_LOAD_NEXT_EVENT] = load_next_event_transfer;
    condition[SRC_THRESHOLD] = (threshold_value != '0)
      && (memory_word_count >= threshold_value);
    condition[SRC_ACQ_DONE] = mcs_mode ? acquisition_complete : preset_reached;
    condition[SRC_OVERFLOW] = counter_overflow && non_clearing_mode;
    condition[SRC_ALMOST_FULL] = queue_almost_full;
    condition = condition & SRC_USED_MASK;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source flags.

  // Clear strobes for each flag cell. A clear only matters for the edge
  // cells; the level cells follow their condition and ignore it.
  // write clear or queue key
  always_comb
  begin
    clear = write_ctl ? reg_wdata[CTL_CLEAR_LSB +: NUM_SOURCES] : '0;
    clear[SRC_ALMOST_FULL] = clear[SRC_ALMOST_FULL] || queue_reset_key;
    if (ack_hit && release_mode == VSI_RELEASE_ON_ACKNOWLEDGE)
      clear = clear | status;
  end

  // Reserved sources still get a cell so the read map stays regular; their
  // condition is tied low above, so the cell never sets.
  // one flag cell each
  for (genvar i = 0; i < NUM_SOURCES; i++)
  begin : g_src
    vsi_source_flag #(.EDGE(SRC_EDGE_MASK[i])) u_flag
    (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .condition(condition[i]),
      .clear(clear[i]),
      .flag(flag[i])
    );
  end

  // The internal flag is shown even with the global enable off, so software
  // can poll the sources without raising a bus request.
  // status and request logic
  assign status = flag & enable;
  assign internal_flag = |status;
  assign next_request = internal_flag && configuration[CFG_GLOBAL_EN_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Register writes.

  // Only bits 12..0 are stored; the upper bits read back as zero.
  // configuration zero at reset
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      configuration <= RST_INTERRUPT_CONFIGURATION[CFG_USED_W-1:0];
    else if (write_cfg)
      configuration <= reg_wdata[CFG_USED_W-1:0];
  end

  // Enable bits; in acknowledge release mode a serviced source stays off until re-enabled.
  // A disable in the same write as an enable wins, so a set-and-clear
  // write always leaves the source off rather than in an unknown state.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      enable <= RST_ENABLE;
    else
    begin
      enable <= (enable
        | (write_ctl ? reg_wdata[CTL_ENABLE_LSB +: NUM_SOURCES] : '0))
        & ~(write_ctl ? reg_wdata[CTL_DISABLE_LSB +: NUM_SOURCES] : '0)
        & ~((ack_hit && release_mode == VSI_RELEASE_ON_ACKNOWLEDGE)
          ? status : '0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered on the read strobe.

  // Flags and statuses are those of the read edge; an event in the same
  // cycle shows up on the next read.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      reg_rdata <= '0;
    else if (reg_read)
    begin
      reg_rdata <= '0;
      if (reg_addr == OFS_INTERRUPT_CONFIGURATION)
        reg_rdata[CFG_USED_W-1:0] <= configuration;
      else if (reg_addr == OFS_INTERRUPT_CONTROL_STATUS)
      begin
        reg_rdata[CTL_ENABLE_LSB +: NUM_SOURCES] <= enable;
        reg_rdata[CTL_CLEAR_LSB +: NUM_SOURCES] <= flag;
        reg_rdata[CTL_STATUS_LSB +: NUM_SOURCES] <= status;
        reg_rdata[CTL_BUS_REQ_BIT] <= irq_request;
        reg_rdata[CTL_INTERNAL_BIT] <= internal_flag;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus interrupter.

  // The request follows the internal flag one cycle late; the level is
  // registered too, so a level change reaches the bus one cycle after the
  // configuration write.
  // request gated globally
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      irq_request <= 1'b0;
      irq_level <= 3'h0;
    end
    else
    begin
      irq_request <= next_request;
      irq_level <= configuration[CFG_LEVEL_LSB +: CFG_LEVEL_W];
    end
  end

  // An acknowledge is ours only while we drive the vector, in VSI_ACK_DRIVE.
  assign ack_hit = ack_done && (ack_state == VSI_ACK_DRIVE);

  // The vector is captured on entry and held while driving, so a
  // configuration write during an acknowledge cannot tear the vector.
  // A master that drops the cycle without a completion releases the lines
  // and leaves enables and flags untouched.
  // vector interrupter cycle
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ack_state <= VSI_ACK_IDLE;
      vector_data <= 8'h00;
      vector_data_oe_n <= 1'b1;
    end
    else
    begin
      unique case (ack_state)
        VSI_ACK_IDLE:
        begin
          if (ack_cycle && irq_request && ack_level == irq_level)
          begin
            ack_state <= VSI_ACK_DRIVE;
            vector_data <= configuration[CFG_VECTOR_LSB +: CFG_VECTOR_W];
            vector_data_oe_n <= 1'b0;
          end
        end
        VSI_ACK_DRIVE:
        begin
          if (ack_done || !ack_cycle)
          begin
            ack_state <= VSI_ACK_IDLE;
            vector_data_oe_n <= 1'b1;
          end
        end
        default:
          ack_state <= VSI_ACK_IDLE;
      endcase
    end
  end
endmodule // vsi_interrupt_logic
`default_nettype wire

// ===== verif/vsi_interrupt_logic_sva.sv
/* Checker for the interrupt logic, watching the top module's ports.
   Assumes one clock and the register offsets of the package. */
`timescale 1ns/100ps
`default_nettype none
module vsi_interrupt_logic_sva
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic ack_cycle,
  input wire logic [2:0] ack_level,
  input wire logic ack_done,
  input wire logic irq_request,
  input wire logic [2:0] irq_level,
  input wire logic [7:0] vector_data,
  input wire logic vector_data_oe_n
);
  import vsi_pkg::*;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  logic [12:0] cfg_s;
  //////////////////////////////////////////////////////////////////////////
  // Shadow of the configuration word, so outputs can be tied to it.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      cfg_s <= 13'h0000;
    else if (reg_write && reg_addr == OFS_INTERRUPT_CONFIGURATION)
      cfg_s <= reg_wdata[12:0];
  end
  // Port relations, each tied to its cause.
  oe_release_a: assert property (
    (!ack_cycle || ack_done) |=> vector_data_oe_n)
    else $error("vector lines still driven");
  ack_drive_a: assert property (ack_cycle && irq_request && !ack_done &&
    vector_data_oe_n && ack_level == irq_level
    |=> !vector_data_oe_n && vector_data == cfg_s[7:0])
    else $error("acknowledge vector wrong");
  gen_off_a: assert property (!cfg_s[11] |=> !irq_request)
    else $error("request without global enable");
  level_cfg_a: assert property (reg_write && reg_addr ==
    OFS_INTERRUPT_CONFIGURATION |->
    ##2 irq_level == $past(reg_wdata[10:8], 2))
    else $error("level not taken from configuration");
  rdata_hold_a: assert property (!reg_read |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  unmapped_read_a: assert property (reg_read && reg_addr != 8'h08 &&
    reg_addr != 8'h0C |=> reg_rdata == 32'h00000000)
    else $error("unmapped read not zero");
  cfg_read_a: assert property (reg_read && reg_addr ==
    OFS_INTERRUPT_CONFIGURATION |=> reg_rdata == {19'h00000, cfg_s})
    else $error("configuration readback wrong");
  req_bit_a: assert property (reg_read && reg_addr ==
    OFS_INTERRUPT_CONTROL_STATUS |=> reg_rdata[15] == $past(irq_request))
    else $error("request bit differs from request line");
  cover property (!vector_data_oe_n);
  cover property ($rose(irq_request));
  cover property (reg_write && reg_addr == OFS_INTERRUPT_CONTROL_STATUS);
endmodule // vsi_interrupt_logic_sva
bind vsi_interrupt_logic vsi_interrupt_logic_sva u_vsi_interrupt_logic_sva
(
  .clk_sys, .sys_rst, .reg_write, .reg_read, .reg_addr, .reg_wdata,
  .reg_rdata, .ack_cycle, .ack_level, .ack_done, .irq_request, .irq_level,
  .vector_data, .vector_data_oe_n
);
`default_nettype wire

// ===== verif/vsi_master_model.sv
/* Bus master model that runs interrupt acknowledge cycles.
   Assumes it shares clk_sys and sees the block's vector lines. */
`timescale 1ns/100ps
`default_nettype none
module vsi_master_model
(
  input wire logic clk_sys,
  input wire logic [7:0] vector_data,
  input wire logic vector_data_oe_n,
  output logic ack_cycle,
  output logic [2:0] ack_level,
  output logic ack_done
);
  // Idle bus at time zero.
  initial
  begin
    ack_cycle = 1'b0;
    ack_level = 3'h0;
    ack_done = 1'b0;
  end
  // One acknowledge; a silent interrupter ends it after six cycles
  // without a completion, so no other device is falsely released.
  task automatic ack(input logic [2:0] lvl, input int slow,
    output logic [7:0] vec, output logic got);
    int n;
    @(posedge clk_sys);
    #1;
    ack_cycle = 1'b1;
    ack_level = lvl;
    got = 1'b0;
    for (n = 0; n < 6 && !got; n++)
    begin
      @(posedge clk_sys);
      got = (vector_data_oe_n === 1'b0);
    end
    repeat (slow) @(posedge clk_sys);
    vec = vector_data;
    #1;
    ack_done = got;
    @(posedge clk_sys);
    #1;
    ack_done = 1'b0;
    ack_cycle = 1'b0;
    ack_level = ~lvl; // Released lines show no stale level.
  endtask
endmodule // vsi_master_model
`default_nettype wire

// ===== verif/vme_scaler_interrupt_logic_tb_top.sv
/* Bench for the interrupt logic with a bit-level model of its registers.
   Assumes package, design, master model and checker compiled first. */
`timescale 1ns/100ps
`default_nettype none
module vme_scaler_interrupt_logic_tb_top;
  import vsi_pkg::*;
  localparam int BT[7] = '{0, 1, 2, 3, 4, 5, 7};
  localparam int SR[7] = '{0, 0, 0, 2, 2, 3, 4};
  localparam int MD[7] = '{1, 3, 0, 1, 0, 0, 0};
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic [10:0] cnd = 11'h000;
  logic [31:0] wc = 32'h00000000;
  logic [31:0] th = 32'h00000000;
  logic [31:0] reg_rdata, d, e;
  logic [2:0] irq_level, ack_level;
  logic [7:0] vector_data, v;
  logic [7:0] en = 8'h00;
  logic [7:0] flg = 8'h00;
  logic [12:0] cfg = 13'h0000;
  logic irq_request, vector_data_oe_n, ack_cycle, ack_done, got;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  integer seed = 32'h8C116B69;
  vsi_interrupt_logic u_vsi_interrupt_logic
  (
    .clk_sys, .sys_rst, .reg_write, .reg_read, .reg_addr, .reg_wdata,
    .reg_rdata, .mcs_mode(cnd[9]), .prescale_active(cnd[10]),
    .load_next_event_transfer(cnd[0]), .prescaler_rundown(cnd[1]),
    .clock_shadow(cnd[2]), .memory_word_count(wc), .threshold_value(th),
    .acquisition_complete(cnd[3]), .preset_reached(cnd[4]),
    .counter_overflow(cnd[5]), .non_clearing_mode(cnd[6]),
    .queue_almost_full(cnd[7]), .queue_reset_key(cnd[8]), .ack_cycle,
    .ack_level, .ack_done, .irq_request, .irq_level, .vector_data,
    .vector_data_oe_n
  );
  vsi_master_model u_vsi_master_model
  (
    .clk_sys, .vector_data, .vector_data_oe_n, .ack_cycle, .ack_level,
    .ack_done
  );
  //////////////////////////////////////////////////////////////////////////
  // Clock of 4 ns period.
  always #2 clk_sys = ~clk_sys;
  // Cycle ceiling so a stuck handshake cannot hang the run.
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] gv, input logic [31:0] ev);
    n_checks++;
    if (gv !== ev)
    begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, gv, ev);
    end
  endtask
  // One register access; the strobe is held across its taking edge.
  task automatic acc(input logic w, input logic [7:0] a,
    input logic [31:0] x, output logic [31:0] q);
    @(posedge clk_sys);
    #1;
    reg_write = w;
    reg_read = !w;
    reg_addr = a;
    reg_wdata = x;
    @(posedge clk_sys);
    #1;
    reg_write = 1'b0;
    reg_read = 1'b0;
    @(posedge clk_sys);
    #1;
    q = reg_rdata;
  endtask
  task automatic w3();
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  task automatic put(input int b, input logic val);
    @(posedge clk_sys);
    #1;
    cnd[b] = val;
    w3();
  endtask
  // Control word expected from the model, then compared with the design.
  task automatic ctl();
    e = {en & flg, flg, |(en & flg) & cfg[11], |(en & flg), 6'h00, en};
    acc(1'b0, OFS_INTERRUPT_CONTROL_STATUS, 32'h0, d);
    chk(d, e);
    chk({31'h0, irq_request}, {31'h0, e[15]});
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, sources, release modes.
  initial
  begin
    repeat (20) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    acc(1'b0, OFS_INTERRUPT_CONFIGURATION, 32'h0, d);
    chk(d, RST_INTERRUPT_CONFIGURATION);
    acc(1'b1, 8'h04, 32'hFFFFFFFF, d);
    acc(1'b0, 8'h04, 32'h0, d);
    chk(d, 32'h00000000);
    ctl();
    d = $random(seed);
    cfg = {2'b01, d[10:0]};
    acc(1'b1, OFS_INTERRUPT_CONFIGURATION, {19'h0, cfg}, d);
    acc(1'b0, OFS_INTERRUPT_CONFIGURATION, 32'h0, d);
    chk(d, {19'h0, cfg});
    chk({29'h0, irq_level}, {29'h0, cfg[10:8]});
    $display("reset and configuration done");
    acc(1'b1, OFS_INTERRUPT_CONTROL_STATUS, 32'h000000FF, d);
    en = 8'hFF;
    ctl();
    put(5, 1'b1);
    ctl();
    put(5, 1'b0);
    cnd[6] = 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      cnd[10:9] = 2'(MD[i]);
      put(BT[i], 1'b1);
      flg[SR[i]] = 1'b1;
      ctl();
      put(BT[i], 1'b0);
      flg[SR[i]] = SRC_EDGE_MASK[SR[i]];
      ctl();
      if (i == 6)
        put(8, 1'b1);
      else
        acc(1'b1, OFS_INTERRUPT_CONTROL_STATUS, 32'h1 << (16 + SR[i]), d);
      flg[SR[i]] = 1'b0;
      ctl();
    end
    put(8, 1'b0);
    d = $random(seed);
    wc = 32'd4 + d[7:0];
    w3();
    ctl();
    th = 32'd4;
    wc = 32'd3;
    w3();
    ctl();
    wc = 32'd4;
    flg[1] = 1'b1;
    w3();
    ctl();
    wc = 32'd0;
    flg[1] = 1'b0;
    w3();
    ctl();
    $display("source tests done");
    cfg[11] = 1'b0;
    acc(1'b1, OFS_INTERRUPT_CONFIGURATION, {19'h0, cfg}, d);
    put(5, 1'b1);
    flg[3] = 1'b1;
    ctl();
    cfg[11] = 1'b1;
    acc(1'b1, OFS_INTERRUPT_CONFIGURATION, {19'h0, cfg}, d);
    repeat (10) @(posedge clk_sys);
    ctl();
    acc(1'b1, OFS_INTERRUPT_CONTROL_STATUS, 32'h00000808, d);
    en[3] = 1'b0;
    ctl();
    acc(1'b1, OFS_INTERRUPT_CONTROL_STATUS, 32'h00000008, d);
    en[3] = 1'b1;
    ctl();
    put(5, 1'b0);
    flg[3] = 1'b0;
    $display("register access release done");
    cfg[12] = 1'b1;
    acc(1'b1, OFS_INTERRUPT_CONFIGURATION, {19'h0, cfg}, d);
    cnd[10:9] = 2'b01;
    put(0, 1'b1);
    put(0, 1'b0);
    flg[0] = 1'b1;
    u_vsi_master_model.ack(~cfg[10:8], 0, v, got);
    chk({31'h0, got}, 32'h0);
    u_vsi_master_model.ack(cfg[10:8], 2, v, got);
    chk({23'h0, got, v}, {23'h0, 1'b1, cfg[7:0]});
    w3();
    en[0] = 1'b0;
    flg[0] = 1'b0;
    ctl();
    acc(1'b1, OFS_INTERRUPT_CONTROL_STATUS, 32'h00000001, d);
    en[0] = 1'b1;
    put(0, 1'b1);
    put(0, 1'b0);
    flg[0] = 1'b1;
    ctl();
    $display("acknowledge release done");
    end_sim();
  end
endmodule // vme_scaler_interrupt_logic_tb_top
`default_nettype wire
